/* File: shared/i2cse_pkg.sv */
// package of constants for the slave restart status event block
// assumes a single system clock domain; bus pins are sampled, not clocked on
package i2cse_pkg;
    // status register field positions
    localparam int ST_PFX_LSB  = 4;
    localparam int ST_TRC_BIT  = 3;
    localparam int ST_ACK_BIT  = 2;
    localparam int ST_STD_BIT  = 1;
    localparam int ST_SPD_BIT  = 0;
    // status reset value and fixed patterns
    localparam logic [7:0] ST_RESET = 8'h00;
    localparam logic [7:0] ST_START = 8'h02;
    localparam logic [7:0] ST_STOP  = 8'h01;
    localparam logic [7:0] ST_EXT_9 = 8'h26;
    // status upper nibble per addressing kind
    localparam logic [3:0] PFX_MATCH = 4'h1;
    localparam logic [3:0] PFX_EXT   = 4'h2;
    localparam logic [3:0] PFX_NONE  = 4'h0;
    // extension code address prefixes
    localparam logic [3:0] EXT_LO_HI4 = 4'h0;
    localparam logic [4:0] EXT_HI_HI5 = 5'h1e;
    // bit count of one byte and of the acknowledge slot
    localparam logic [3:0] BITS_DATA = 4'h8;
    // own address reset value
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DATA,
        PH_IGNORE
    } i2cse_phase_type;
endpackage

/* File: shared/i2cse_stream_if.sv */
// valid/ready byte stream between the event logic and its buffer
// assumes both ends share one clock
`timescale 1ns/1ps
interface i2cse_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input  ready);
    modport snk (input  valid, input  data, output ready);
endinterface

/* File: src/i2cse_buffer.sv */
// two-entry buffer: a head register and a skid register
// assumes the source holds valid and data until ready
`timescale 1ns/1ps
module i2cse_buffer
    import i2cse_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    nrst,
    // filling side
    i2cse_stream_if.snk  fill,
    // draining side
    i2cse_stream_if.src  drain
);
    logic             head_vld_ff, nxt_head_vld;
    logic             skid_vld_ff, nxt_skid_vld;
    logic [WIDTH-1:0] head_ff, nxt_head;
    logic [WIDTH-1:0] skid_ff, nxt_skid;

    if (WIDTH < 1) begin : g_bad_width
        $error("buffer width must be at least one bit");
    end

    // ready comes from a flop so the source never sees a combinational loop
    assign fill.ready  = !skid_vld_ff;
    assign drain.valid = head_vld_ff;
    assign drain.data  = head_ff;

    // head refills from skid first to keep arrival order
    always_comb begin
        nxt_head_vld = head_vld_ff;
        nxt_skid_vld = skid_vld_ff;
        nxt_head     = head_ff;
        nxt_skid     = skid_ff;
        if (drain.ready && head_vld_ff) begin
            nxt_head_vld = skid_vld_ff;
            nxt_head     = skid_ff;
            nxt_skid_vld = 1'b0;
        end
        if (fill.valid && !skid_vld_ff) begin
            if (!nxt_head_vld) begin
                nxt_head_vld = 1'b1;
                nxt_head     = fill.data;
            end else begin
                nxt_skid_vld = 1'b1;
                nxt_skid     = fill.data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            head_vld_ff <= 1'b0;
            skid_vld_ff <= 1'b0;
            head_ff     <= '0;
            skid_ff     <= '0;
        end else begin
            head_vld_ff <= nxt_head_vld;
            skid_vld_ff <= nxt_skid_vld;
            head_ff     <= nxt_head;
            skid_ff     <= nxt_skid;
        end
    end
endmodule

/* File: src/i2cse_slave.sv */
// slave side status and event logic of a two-wire bus, restart aware
// assumes an external master drives the bus clock; pins arrive asynchronously
`timescale 1ns/1ps
module i2cse_slave
    import i2cse_pkg::*;
#(
    parameter int DATA_WIDTH = 8
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // bus pins, open drain; oe high pulls the wire low
    input  wire logic       scl_in,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_oe,
    // control bits
    input  wire logic [6:0] own_slave_address,
    input  wire logic       irq_timing_select,
    input  wire logic       start_irq_enable,
    input  wire logic       stop_irq_enable,
    // status and event
    output logic [7:0]      bus_status_reg,
    output logic            irq,
    // received data stream
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    if (DATA_WIDTH != 8) begin : g_bad_data_width
        $error("the bus carries eight-bit bytes only");
    end

    // extension code is a reserved address group
    function automatic logic is_ext_code(input logic [6:0] adr);
        is_ext_code = (adr[6:3] == EXT_LO_HI4) || (adr[6:2] == EXT_HI_HI5);
    endfunction

    function automatic logic [7:0] pack_status(input logic [3:0] pfx, input logic trc,
                                               input logic ack, input logic std);
        pack_status = {pfx, trc, ack, std, 1'b0};
    endfunction

    i2cse_stream_if #(.WIDTH(8)) push_if ();
    i2cse_stream_if #(.WIDTH(8)) pop_if ();

    // pin synchronisers; only the second stage and its delayed copy feed any logic
    logic scl_s1_ff, scl_s2_ff, scl_d_ff;
    logic sda_s1_ff, sda_s2_ff, sda_d_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_d_ff  <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_d_ff  <= 1'b1;
        end else begin
            scl_s1_ff <= scl_in;
            scl_s2_ff <= scl_s1_ff;
            scl_d_ff  <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_d_ff  <= sda_s2_ff;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s2_ff && !scl_d_ff;
    assign scl_fall  = !scl_s2_ff && scl_d_ff;
    assign start_det = scl_s2_ff && scl_d_ff && !sda_s2_ff && sda_d_ff;
    assign stop_det  = scl_s2_ff && scl_d_ff && sda_s2_ff && !sda_d_ff;

    // protocol state
    i2cse_phase_type phase_ff, nxt_phase;
    logic [3:0] bitcnt_ff, nxt_bitcnt;
    logic [7:0] shift_ff, nxt_shift;
    logic       rw_ff, nxt_rw;
    logic       ext_ff, nxt_ext;
    logic       was_addr_ff, nxt_was_addr;
    logic       ack_ff, nxt_ack;
    logic [7:0] status_ff, nxt_status;
    logic       irq_ff, nxt_irq;
    logic       sda_oe_ff, nxt_sda_oe;
    logic       scl_oe_ff, nxt_scl_oe;
    logic       push_vld_ff, nxt_push_vld;
    logic [7:0] push_data_ff, nxt_push_data;
    logic       adr_match, adr_ext;
    logic [3:0] pfx;

    assign adr_match = (shift_ff[7:1] == own_slave_address);
    assign adr_ext   = is_ext_code(shift_ff[7:1]);
    assign pfx       = ext_ff ? PFX_EXT : PFX_MATCH;

    always_comb begin
        nxt_phase     = phase_ff;
        nxt_bitcnt    = bitcnt_ff;
        nxt_shift     = shift_ff;
        nxt_rw        = rw_ff;
        nxt_ext       = ext_ff;
        nxt_was_addr  = was_addr_ff;
        nxt_ack       = ack_ff;
        nxt_status    = status_ff;
        nxt_irq       = 1'b0;
        nxt_sda_oe    = sda_oe_ff;
        nxt_push_vld  = push_vld_ff && !push_if.ready;
        nxt_push_data = push_data_ff;
        // stretch the bus clock while a byte waits for buffer room
        nxt_scl_oe    = nxt_push_vld;
        if (stop_det) begin
            nxt_phase  = PH_IDLE;
            nxt_status = ST_STOP;
            nxt_irq    = stop_irq_enable;
            nxt_sda_oe = 1'b0;
        end else if (start_det) begin
            // a restart shows the start bit but raises no event
            nxt_irq      = (phase_ff == PH_IDLE) && start_irq_enable;
            nxt_status   = ST_START;
            nxt_phase    = PH_ADDR;
            // the clock fall that closes the start is no bit; it wraps this to zero
            nxt_bitcnt   = '1;
            nxt_ext      = 1'b0;
            nxt_was_addr = 1'b0;
            nxt_sda_oe   = 1'b0;
        end else if (phase_ff != PH_IDLE) begin
            if (scl_rise) begin
                if (bitcnt_ff == BITS_DATA) begin
                    nxt_ack = !sda_s2_ff;
                end else begin
                    nxt_shift = {shift_ff[6:0], sda_s2_ff};
                end
            end else if (scl_fall && bitcnt_ff != BITS_DATA) begin
                nxt_bitcnt = bitcnt_ff + 4'h1;
                if (nxt_bitcnt == BITS_DATA) begin
                    // eighth clock: byte complete, acknowledge slot follows
                    nxt_was_addr = (phase_ff == PH_ADDR);
                    unique case (phase_ff)
                        PH_ADDR: begin
                            nxt_rw = shift_ff[0];
                            if (adr_match) begin
                                nxt_phase  = PH_DATA;
                                nxt_status = pack_status(PFX_MATCH, shift_ff[0], 1'b1, 1'b1);
                                nxt_irq    = !irq_timing_select;
                                nxt_sda_oe = 1'b1;
                            end else if (adr_ext) begin
                                nxt_phase  = PH_DATA;
                                nxt_ext    = 1'b1;
                                nxt_status = pack_status(PFX_EXT, shift_ff[0], 1'b0, 1'b1);
                                nxt_irq    = 1'b1;
                                nxt_sda_oe = 1'b1;
                            end else begin
                                nxt_phase  = PH_IGNORE;
                                nxt_status = pack_status(PFX_NONE, shift_ff[0], 1'b0, 1'b1);
                                nxt_irq    = !irq_timing_select;
                            end
                        end
                        PH_DATA: begin
                            // ack bit still clear before the acknowledge slot
                            nxt_status = pack_status(pfx, rw_ff, 1'b0, 1'b0);
                            nxt_irq    = !irq_timing_select;
                            if (!rw_ff) begin
                                nxt_sda_oe    = 1'b1;
                                nxt_push_vld  = 1'b1;
                                nxt_push_data = shift_ff;
                                nxt_scl_oe    = 1'b1;
                            end
                        end
                        PH_IGNORE: begin
                            nxt_was_addr = 1'b0;
                        end
                        default: begin
                            nxt_phase = PH_IDLE;
                        end
                    endcase
                end
            end else if (scl_fall) begin
                // ninth clock: acknowledge done, next byte begins
                nxt_bitcnt = '0;
                nxt_sda_oe = 1'b0;
                if (irq_timing_select) begin
                    if (phase_ff == PH_IGNORE) begin
                        nxt_irq    = was_addr_ff;
                        nxt_status = pack_status(PFX_NONE, rw_ff, ack_ff, 1'b1);
                    end else if (was_addr_ff && ext_ff) begin
                        nxt_irq    = 1'b1;
                        nxt_status = ST_EXT_9;
                    end else if (was_addr_ff) begin
                        nxt_irq    = 1'b1;
                        nxt_status = pack_status(PFX_MATCH, rw_ff, 1'b1, 1'b1);
                    end else begin
                        nxt_irq    = 1'b1;
                        nxt_status = pack_status(pfx, rw_ff, ack_ff, 1'b0);
                    end
                end
                nxt_was_addr = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_ff     <= PH_IDLE;
            bitcnt_ff    <= '0;
            shift_ff     <= '0;
            rw_ff        <= 1'b0;
            ext_ff       <= 1'b0;
            was_addr_ff  <= 1'b0;
            ack_ff       <= 1'b0;
            status_ff    <= ST_RESET;
            irq_ff       <= 1'b0;
            sda_oe_ff    <= 1'b0;
            scl_oe_ff    <= 1'b0;
            push_vld_ff  <= 1'b0;
            push_data_ff <= '0;
        end else begin
            phase_ff     <= nxt_phase;
            bitcnt_ff    <= nxt_bitcnt;
            shift_ff     <= nxt_shift;
            rw_ff        <= nxt_rw;
            ext_ff       <= nxt_ext;
            was_addr_ff  <= nxt_was_addr;
            ack_ff       <= nxt_ack;
            status_ff    <= nxt_status;
            irq_ff       <= nxt_irq;
            sda_oe_ff    <= nxt_sda_oe;
            scl_oe_ff    <= nxt_scl_oe;
            push_vld_ff  <= nxt_push_vld;
            push_data_ff <= nxt_push_data;
        end
    end

    // received bytes go through the buffer so a slow reader loses none
    assign push_if.valid = push_vld_ff;
    assign push_if.data  = push_data_ff;
    assign pop_if.ready  = rx_ready;

    i2cse_buffer #(.WIDTH(8)) u_buffer (
        .clk   (clk),
        .nrst  (nrst),
        .fill  (push_if.snk),
        .drain (pop_if.src)
    );

    // outputs
    assign bus_status_reg = status_ff;
    assign irq            = irq_ff;
    assign sda_oe         = sda_oe_ff;
    assign scl_oe         = scl_oe_ff;
    assign rx_data        = pop_if.data;
    assign rx_valid       = pop_if.valid;
endmodule

/* File: tb/i2cse_slave_assertions.sv */
// concurrent checks of the slave status and event outputs
// assumes one clock domain; pins are sampled raw here, the design adds two flops
`timescale 1ns/1ps
module i2cse_slave_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // bus wires and acknowledge pull
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe,
    // control and status
    input wire logic       irq_timing_select,
    input wire logic       stop_irq_enable,
    input wire logic [7:0] bus_status_reg,
    input wire logic       irq
);
    logic quiet_ff;
    logic nxt_quiet;
    logic refused_evt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // a refused address silences events; start status 02 is excluded as ambiguous
    assign refused_evt = irq && bus_status_reg[7:4] == 4'h0 && bus_status_reg[1:0] == 2'b10
                         && bus_status_reg != 8'h02;

    // silence lasts until stop or restart shows in status
    always_comb begin
        nxt_quiet = quiet_ff;
        if (refused_evt) begin
            nxt_quiet = 1'b1;
        end else if (bus_status_reg == 8'h01 || bus_status_reg == 8'h02) begin
            nxt_quiet = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            quiet_ff <= 1'b0;
        end else begin
            quiet_ff <= nxt_quiet;
        end
    end

    AST_START_STATUS: assert property ($fell(sda_in) && scl_in |-> ##[1:6] bus_status_reg == 8'h02)
        else $error("start not shown in status");
    AST_STOP_STATUS: assert property ($rose(sda_in) && scl_in |-> ##[1:6] bus_status_reg == 8'h01)
        else $error("stop not shown in status");
    AST_STOP_QUIET: assert property ($rose(sda_in) && scl_in && !stop_irq_enable |=> !irq [*6])
        else $error("stop event while disabled");
    AST_STOP_IRQ: assert property ($rose(sda_in) && scl_in && stop_irq_enable |-> ##[1:6] irq)
        else $error("stop event missing");
    AST_MATCH_SEL0: assert property (irq && bus_status_reg[7:4] == 4'h1 && !irq_timing_select
        |-> bus_status_reg[2] == bus_status_reg[1] && !bus_status_reg[0])
        else $error("bad matched status, early timing");
    AST_MATCH_SEL1: assert property (irq && bus_status_reg[7:4] == 4'h1 && irq_timing_select
        |-> !bus_status_reg[0] && (bus_status_reg[2] || !bus_status_reg[1]))
        else $error("bad matched status, late timing");
    AST_EXT_STATUS: assert property (irq && bus_status_reg[7:4] == 4'h2 && irq_timing_select
        |-> !bus_status_reg[0] && (!bus_status_reg[1] || !bus_status_reg[2]
        || bus_status_reg == 8'h26))
        else $error("bad extension status");
    AST_REFUSED_ONCE: assert property (quiet_ff && irq |-> bus_status_reg inside {8'h01, 8'h02})
        else $error("event after refused address");
    AST_ADDR_TIMING: assert property (irq && bus_status_reg[7:4] == 4'h1
        && bus_status_reg[2:0] == 3'b110 |-> $past(sda_oe, 6) == irq_timing_select)
        else $error("address event at wrong clock");
endmodule

bind i2cse_slave i2cse_slave_assertions u_i2cse_slave_assertions (
    .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
    .irq_timing_select(irq_timing_select), .stop_irq_enable(stop_irq_enable),
    .bus_status_reg(bus_status_reg), .irq(irq)
);

/* File: tb/i2cse_master_model.sv */
// behavioural bus master pulling clock and data low, 125 ns bit period
// assumes the bench resolves each wire with a pull-up from every party's pull
`timescale 1ns/1ps
module i2cse_master_model (
    // resolved bus wires
    input  wire logic scl,
    input  wire logic sda,
    // pulls, high drives the wire low
    output logic      scl_low,
    output logic      sda_low,
    // clock falls seen since the byte began
    output int        fall_cnt
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        fall_cnt = 0;
    end

    // counts real wire falls, so a stretch by the slave is honoured
    always @(negedge scl) begin
        fall_cnt = fall_cnt + 1;
    end

    // one clock pulse; data held 35 ns past the fall so no false start is seen
    task automatic pulse();
        #27.5;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #62.5;
        scl_low = 1'b1;
        #35;
    endtask

    // start or restart; the clock stands high when idle
    task automatic bus_start();
        sda_low = 1'b0;
        #27.5;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #62.5;
        sda_low = 1'b1;
        #62.5;
        scl_low = 1'b1;
        #35;
    endtask

    task automatic bus_stop();
        sda_low = 1'b1;
        #27.5;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #62.5;
        sda_low = 1'b0;
        #62.5;
    endtask

    // msb first, then a released acknowledge slot
    task automatic send_byte(input logic [7:0] b);
        fall_cnt = 0;
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            pulse();
        end
        sda_low = 1'b0;
        pulse();
    endtask
endmodule

/* File: tb/i2cse_slave_test.sv */
// self-checking bench of the slave status event block
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/1ps
module i2cse_slave_test;
    import i2cse_pkg::*;
    localparam logic [7:0] OWN_W = 8'h54;
    logic       clk;
    logic       nrst;
    logic       scl_oe;
    logic       sda_oe;
    logic       scl_low;
    logic       sda_low;
    logic       scl;
    logic       sda;
    int         fall_cnt;
    logic [6:0] own_slave_address;
    logic       irq_timing_select;
    logic       start_irq_enable;
    logic       stop_irq_enable;
    logic [7:0] bus_status_reg;
    logic       irq;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic       rx_ready;
    logic [7:0] q_stat[$];
    int         q_fall[$];
    int         bad_count;
    int         n_compared;

    // open-drain wires with pull-up
    assign scl = !(scl_low || scl_oe);
    assign sda = !(sda_low || sda_oe);

    always #2.5 clk = ~clk;

    i2cse_slave u_i2cse_slave (
        .clk(clk), .nrst(nrst), .scl_in(scl), .scl_oe(scl_oe), .sda_in(sda), .sda_oe(sda_oe),
        .own_slave_address(own_slave_address), .irq_timing_select(irq_timing_select),
        .start_irq_enable(start_irq_enable), .stop_irq_enable(stop_irq_enable),
        .bus_status_reg(bus_status_reg), .irq(irq), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready)
    );

    i2cse_master_model u_i2cse_master_model (
        .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low), .fall_cnt(fall_cnt)
    );

    // log each event with the clock fall of its byte; mid-cycle, where outputs are settled
    always @(negedge clk) begin
        if (irq === 1'b1) begin
            q_stat.push_back(bus_status_reg);
            q_fall.push_back(fall_cnt);
        end
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
        n_compared++;
        if ((got & msk) !== (exp & msk)) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // falls of zero means the moment is not judged
    task automatic expect_irq(input logic [7:0] exp, input logic [7:0] msk, input int falls);
        if (q_stat.size() == 0) begin
            bad_count++;
            $display("MISMATCH %0t missing event %h", $time, exp);
        end else begin
            check8(q_stat.pop_front(), exp, msk);
            check8(8'(q_fall.pop_front()), 8'(falls), (falls != 0) ? 8'hff : 8'h00);
        end
    endtask

    task automatic setup(input logic sel, input logic sten, input logic spen);
        @(posedge clk);
        #1;
        irq_timing_select = sel;
        start_irq_enable = sten;
        stop_irq_enable = spen;
        q_stat.delete();
        q_fall.delete();
    endtask

    task automatic scn_match_restart(input logic sel);
        setup(sel, 1'b1, 1'b1);
        u_i2cse_master_model.bus_start();
        u_i2cse_master_model.send_byte(OWN_W);
        u_i2cse_master_model.send_byte(8'ha5);
        u_i2cse_master_model.bus_start();
        check8(bus_status_reg, ST_START, 8'hff);
        u_i2cse_master_model.send_byte(OWN_W);
        u_i2cse_master_model.send_byte(8'h3c);
        u_i2cse_master_model.bus_stop();
        expect_irq(8'h02, 8'hff, 0);
        for (int k = 0; k < 2; k++) begin
            expect_irq(8'h16, 8'hf7, 8 + int'(sel));
            expect_irq(8'h10, sel ? 8'hf3 : 8'hf7, 8 + int'(sel));
        end
        expect_irq(8'h01, 8'hff, 0);
        check8(8'(q_stat.size()), 8'h00, 8'hff);
    endtask

    task automatic scn_ext_restart();
        setup(1'b1, 1'b0, 1'b0);
        u_i2cse_master_model.bus_start();
        u_i2cse_master_model.send_byte(OWN_W);
        u_i2cse_master_model.send_byte(8'h5a);
        u_i2cse_master_model.bus_start();
        u_i2cse_master_model.send_byte(8'hf0);
        u_i2cse_master_model.send_byte(8'h69);
        u_i2cse_master_model.bus_stop();
        check8(bus_status_reg, ST_STOP, 8'hff);
        expect_irq(8'h16, 8'hf7, 9);
        expect_irq(8'h10, 8'hf3, 9);
        expect_irq(8'h22, 8'hf7, 8);
        expect_irq(8'h26, 8'hff, 9);
        expect_irq(8'h20, 8'hf3, 9);
        check8(8'(q_stat.size()), 8'h00, 8'hff);
    endtask

    // refused read address after restart, then two ignored data bytes
    task automatic scn_refused_restart();
        setup(1'b0, 1'b1, 1'b1);
        u_i2cse_master_model.bus_start();
        u_i2cse_master_model.send_byte(OWN_W);
        u_i2cse_master_model.send_byte(8'h11);
        u_i2cse_master_model.bus_start();
        u_i2cse_master_model.send_byte(8'hab);
        u_i2cse_master_model.send_byte(8'h22);
        u_i2cse_master_model.send_byte(8'h33);
        u_i2cse_master_model.bus_stop();
        expect_irq(8'h02, 8'hff, 0);
        expect_irq(8'h16, 8'hf7, 8);
        expect_irq(8'h10, 8'hf7, 8);
        expect_irq(8'h02, 8'hf3, 8);
        expect_irq(8'h01, 8'hff, 0);
        check8(8'(q_stat.size()), 8'h00, 8'hff);
    endtask

    task automatic take_byte(input logic [7:0] exp);
        @(posedge clk);
        #1;
        for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check8({rx_valid, rx_data[6:0]}, {1'b1, exp[6:0]}, 8'hff);
        check8(rx_data, exp, 8'hff);
        rx_ready = 1'b1;
        @(posedge clk);
        #1;
        rx_ready = 1'b0;
    endtask

    // receiver stalls: two bytes fill the buffer, the third must stretch the clock
    // runs on a second own address so the address compare sees more than one value
    task automatic scn_buffer_stall();
        int held;
        setup(1'b0, 1'b0, 1'b0);
        own_slave_address = 7'h3b;
        rx_ready = 1'b0;
        held = 0;
        fork
            begin
                u_i2cse_master_model.bus_start();
                u_i2cse_master_model.send_byte(8'h76);
                u_i2cse_master_model.send_byte(8'hc1);
                u_i2cse_master_model.send_byte(8'hc2);
                u_i2cse_master_model.send_byte(8'hc3);
                u_i2cse_master_model.bus_stop();
            end
        join_none
        // a one-cycle pull per byte is normal; only a long one is a real stall
        for (int n = 0; n < 20000 && held < 50; n++) begin
            @(posedge clk);
            #1;
            held = (scl_oe === 1'b1) ? held + 1 : 0;
        end
        check8({7'h00, scl_oe}, 8'h01, 8'hff);
        take_byte(8'hc1);
        take_byte(8'hc2);
        take_byte(8'hc3);
        wait fork;
        check8({7'h00, rx_valid}, 8'h00, 8'hff);
        expect_irq(8'h16, 8'hf7, 8);
        for (int k = 0; k < 3; k++) begin
            expect_irq(8'h10, 8'hf7, 8);
        end
        check8(8'(q_stat.size()), 8'h00, 8'hff);
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // whole run needs about 26 us; a stuck stretch ends here
    initial begin
        #300000;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        own_slave_address = OWN_W[7:1];
        irq_timing_select = 1'b0;
        start_irq_enable = 1'b0;
        stop_irq_enable = 1'b0;
        rx_ready = 1'b1;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        scn_match_restart(1'b0);
        scn_match_restart(1'b1);
        scn_ext_restart();
        scn_refused_restart();
        scn_buffer_stall();
        complete_run();
    end
endmodule
